// *** hw/serial_port_pkg.sv ***
// shared constants and types of the four-mode serial port
package serial_port_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h98;
  localparam logic [7:0] ADDR_DATA  = 8'h99;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // control field positions
  localparam int CB_MODE_HI = 7;
  localparam int CB_MODE_LO = 6;
  localparam int CB_MPEN    = 5;
  localparam int CB_RXEN    = 4;
  localparam int CB_TXNINTH = 3;
  localparam int CB_RXNINTH = 2;
  localparam int CB_TXDONE  = 1;
  localparam int CB_RXDONE  = 0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 25;
  localparam int M0_CLKS_PER_BIT = 12;
  localparam int M0_CLK_HIGH_AT  = 6;
  localparam int FIXED_DIV_SLOW  = 64;
  localparam int FIXED_DIV_FAST  = 32;
  localparam int SAMPLES_DEFAULT = 16;
  localparam int DATA_BITS       = 8;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_FIXED = 2'b10,
    MODE_TIMED = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b11,
    TX_STOP  = 2'b10
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } rx_state_t;

  typedef enum logic [1:0] {
    M0_IDLE = 2'b00,
    M0_TX   = 2'b01,
    M0_RX   = 2'b11
  } shift_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage : serial_port_pkg

// *** hw/four_mode_serial_port.sv ***
// four-mode serial port: shift register mode and three framed modes
`timescale 1ns/100ps

module four_mode_serial_port #(
  parameter int SAMPLES = serial_port_pkg::SAMPLES_DEFAULT
) (
  // system clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  // special-function register port
  input  wire serial_port_pkg::sfr_req_t sfrReq,
  output logic [7:0]                     sfrRdData,
  // timer overflow pulses, link clock domain
  input  wire logic                      linkClk,
  input  wire logic [1:0]                timerOvf,
  // rate controls held outside
  input  wire logic                      rateDouble,
  input  wire logic                      useTimer2,
  // serial pins
  input  wire logic                      rxdIn,
  output logic                           rxdOut,
  output logic                           rxdOe_n,
  output logic                           txd
);

  localparam int SW = $clog2(SAMPLES);
  localparam logic [SW-1:0] SMP_MID  = SW'(SAMPLES / 2 - 1);
  localparam logic [SW-1:0] SMP_LAST = SW'(SAMPLES - 1);
  localparam logic [4:0] PRE_SLOW =
    5'(serial_port_pkg::FIXED_DIV_SLOW / SAMPLES - 1);
  localparam logic [4:0] PRE_FAST =
    5'(serial_port_pkg::FIXED_DIV_FAST / SAMPLES - 1);
  localparam logic [3:0] M0_LAST =
    4'(serial_port_pkg::M0_CLKS_PER_BIT - 1);
  localparam logic [3:0] M0_HIGH =
    4'(serial_port_pkg::M0_CLK_HIGH_AT);
  localparam logic [3:0] LAST8 = 4'(serial_port_pkg::DATA_BITS - 1);
  localparam logic [3:0] LAST9 = 4'(serial_port_pkg::DATA_BITS);

  if (SAMPLES < 4 || SAMPLES > 16 ||
      (serial_port_pkg::FIXED_DIV_FAST % (2 * SAMPLES)) != 0) begin : g_chk
    $error("SAMPLES must be 4, 8 or 16");
  end

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [7:0]                    ctrl_ff;
  logic [7:0]                    nxt_ctrl;
  logic [7:0]                    rxBuf_ff;
  logic [7:0]                    rdData_ff;
  logic                          wrCtrl;
  logic                          wrData;
  serial_port_pkg::mode_t        mode;
  logic [1:0]                    ovfTgl_ff;
  logic [1:0]                    ovfS1_ff;
  logic [1:0]                    ovfS2_ff;
  logic [1:0]                    ovfS3_ff;
  logic [1:0]                    ovfSeen_ff;
  logic [1:0]                    ovfPulse;
  logic                          t1Half_ff;
  logic                          timerTick;
  logic [4:0]                    presc_ff;
  logic                          fixedTick;
  logic                          sampleTick;
  logic                          rxS1_ff;
  logic                          rxS2_ff;
  logic                          rxS3_ff;
  logic                          rxLvl_ff;
  logic                          rxPrev_ff;
  serial_port_pkg::tx_state_t    txSt_ff;
  logic [8:0]                    txShift_ff;
  logic [3:0]                    txBits_ff;
  logic [SW-1:0]                 txSmp_ff;
  logic                          txLine_ff;
  logic                          txSetA;
  serial_port_pkg::rx_state_t    rxSt_ff;
  logic [8:0]                    rxShift_ff;
  logic [3:0]                    rxBits_ff;
  logic [SW-1:0]                 rxSmp_ff;
  logic                          rxNinth;
  logic                          rxAccept;
  serial_port_pkg::shift_state_t m0St_ff;
  logic [3:0]                    m0Cnt_ff;
  logic [2:0]                    m0Bits_ff;
  logic [7:0]                    m0Shift_ff;
  logic                          m0End;

  assign wrCtrl = sfrReq.wr && sfrReq.addr == serial_port_pkg::ADDR_CTRL;
  assign wrData = sfrReq.wr && sfrReq.addr == serial_port_pkg::ADDR_DATA;
  assign mode   = serial_port_pkg::mode_t'(
    ctrl_ff[serial_port_pkg::CB_MODE_HI:serial_port_pkg::CB_MODE_LO]
  );

  // ------------------------------------------------------------
  // timer overflow crossing
  // ------------------------------------------------------------
  // each pulse becomes a toggle on the link clock; the system side
  // only acts once the second and third stages agree
  for (genvar i = 0; i < 2; i++) begin : g_ovf
    always_ff @(posedge linkClk or negedge nrst) begin
      if (!nrst) begin
        ovfTgl_ff[i] <= 1'b0;
      end else if (timerOvf[i]) begin
        ovfTgl_ff[i] <= ~ovfTgl_ff[i];
      end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
        ovfS1_ff[i]   <= 1'b0;
        ovfS2_ff[i]   <= 1'b0;
        ovfS3_ff[i]   <= 1'b0;
        ovfSeen_ff[i] <= 1'b0;
      end else begin
        ovfS1_ff[i] <= ovfTgl_ff[i];
        ovfS2_ff[i] <= ovfS1_ff[i];
        ovfS3_ff[i] <= ovfS2_ff[i];
        if (ovfS2_ff[i] == ovfS3_ff[i]) begin
          ovfSeen_ff[i] <= ovfS3_ff[i];
        end
      end
    end

    assign ovfPulse[i] = (ovfS2_ff[i] == ovfS3_ff[i]) &&
                         (ovfS3_ff[i] != ovfSeen_ff[i]);
  end

  // ------------------------------------------------------------
  // sample tick, SAMPLES per bit
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      t1Half_ff <= 1'b0;
    end else if (ovfPulse[0]) begin
      t1Half_ff <= ~t1Half_ff;
    end
  end

  // timer 1 runs at half rate unless doubled; timer 2 at full rate
  assign timerTick = useTimer2 ? ovfPulse[1] :
                     (ovfPulse[0] && (rateDouble || t1Half_ff));

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      presc_ff <= 5'h00;
    end else if (fixedTick) begin
      presc_ff <= 5'h00;
    end else begin
      presc_ff <= presc_ff + 5'h01;
    end
  end

  assign fixedTick = presc_ff >=
                     (rateDouble ? PRE_FAST : PRE_SLOW);
  assign sampleTick = (mode == serial_port_pkg::MODE_FIXED) ?
                      fixedTick : timerTick;

  // ------------------------------------------------------------
  // receive pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxS1_ff   <= 1'b1;
      rxS2_ff   <= 1'b1;
      rxS3_ff   <= 1'b1;
      rxLvl_ff  <= 1'b1;
      rxPrev_ff <= 1'b1;
    end else begin
      rxS1_ff   <= rxdIn;
      rxS2_ff   <= rxS1_ff;
      rxS3_ff   <= rxS2_ff;
      rxPrev_ff <= rxLvl_ff;
      if (rxS2_ff == rxS3_ff) begin
        rxLvl_ff <= rxS3_ff;
      end
    end
  end

  // ------------------------------------------------------------
  // mode 0 shift engine
  // ------------------------------------------------------------
  assign m0End = (m0St_ff != serial_port_pkg::M0_IDLE) &&
                 m0Cnt_ff == M0_LAST &&
                 m0Bits_ff == 3'h7;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      m0St_ff    <= serial_port_pkg::M0_IDLE;
      m0Cnt_ff   <= 4'h0;
      m0Bits_ff  <= 3'h0;
      m0Shift_ff <= 8'hFF;
    end else if (mode == serial_port_pkg::MODE_SHIFT && wrData) begin
      m0St_ff    <= serial_port_pkg::M0_TX;
      m0Cnt_ff   <= 4'h0;
      m0Bits_ff  <= 3'h0;
      m0Shift_ff <= sfrReq.wdata;
    end else begin
      case (m0St_ff)
        serial_port_pkg::M0_IDLE: begin
          // multiprocessor bit deliberately not looked at here
          if (mode == serial_port_pkg::MODE_SHIFT &&
              !ctrl_ff[serial_port_pkg::CB_RXDONE] &&
              ctrl_ff[serial_port_pkg::CB_RXEN]) begin
            m0St_ff  <= serial_port_pkg::M0_RX;
            m0Cnt_ff <= 4'h0;
            m0Bits_ff <= 3'h0;
          end
        end
        serial_port_pkg::M0_TX,
        serial_port_pkg::M0_RX: begin
          if (m0Cnt_ff == M0_LAST) begin
            m0Cnt_ff  <= 4'h0;
            m0Bits_ff <= m0Bits_ff + 3'h1;
            // lsb first both ways: shift right, receive into bit 7
            m0Shift_ff <= {(m0St_ff == serial_port_pkg::M0_RX) ?
                           rxLvl_ff : 1'b1, m0Shift_ff[7:1]};
            if (m0Bits_ff == 3'h7) begin
              m0St_ff <= serial_port_pkg::M0_IDLE;
            end
          end else begin
            m0Cnt_ff <= m0Cnt_ff + 4'h1;
          end
        end
        default: m0St_ff <= serial_port_pkg::M0_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // framed transmitter
  // ------------------------------------------------------------
  assign txSetA = (txSt_ff == serial_port_pkg::TX_DATA) && sampleTick &&
                  txSmp_ff == SMP_LAST && txBits_ff == 4'h0;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      txSt_ff    <= serial_port_pkg::TX_IDLE;
      txShift_ff <= 9'h1FF;
      txBits_ff  <= 4'h0;
      txSmp_ff   <= '0;
      txLine_ff  <= 1'b1;
    end else if (mode != serial_port_pkg::MODE_SHIFT && wrData) begin
      // a write in mid-frame restarts the frame with the new byte
      txSt_ff    <= serial_port_pkg::TX_START;
      txLine_ff  <= 1'b0;
      txSmp_ff   <= '0;
      txShift_ff <= {ctrl_ff[serial_port_pkg::CB_TXNINTH],
                     sfrReq.wdata};
      // mode 1 stops after eight bits, so the ninth is never sent
      txBits_ff  <= (mode == serial_port_pkg::MODE_UART8) ?
                    LAST8 : LAST9;
    end else if (sampleTick) begin
      txSmp_ff <= txSmp_ff + SW'(1);
      if (txSmp_ff == SMP_LAST) begin
        case (txSt_ff)
          serial_port_pkg::TX_IDLE: txLine_ff <= 1'b1;
          serial_port_pkg::TX_START: begin
            txSt_ff    <= serial_port_pkg::TX_DATA;
            txLine_ff  <= txShift_ff[0];
            txShift_ff <= {1'b1, txShift_ff[8:1]};
          end
          serial_port_pkg::TX_DATA: begin
            if (txBits_ff == 4'h0) begin
              txSt_ff   <= serial_port_pkg::TX_STOP;
              txLine_ff <= 1'b1;
            end else begin
              txBits_ff  <= txBits_ff - 4'h1;
              txLine_ff  <= txShift_ff[0];
              txShift_ff <= {1'b1, txShift_ff[8:1]};
            end
          end
          serial_port_pkg::TX_STOP: txSt_ff <= serial_port_pkg::TX_IDLE;
          default: txSt_ff <= serial_port_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // framed receiver
  // ------------------------------------------------------------
  // mode 1 takes the stop level as its ninth bit; modes 2 and 3 keep
  // the real ninth data bit and never look at the stop level
  assign rxNinth = (mode == serial_port_pkg::MODE_UART8) ?
                   rxLvl_ff : rxShift_ff[8];

  // a byte that completes while the previous one is still flagged is
  // dropped: the older byte survives
  assign rxAccept = (rxSt_ff == serial_port_pkg::RX_STOP) && sampleTick &&
                    rxSmp_ff == SMP_MID &&
                    !ctrl_ff[serial_port_pkg::CB_RXDONE] &&
                    (!ctrl_ff[serial_port_pkg::CB_MPEN] ||
                     rxNinth);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxSt_ff    <= serial_port_pkg::RX_IDLE;
      rxShift_ff <= 9'h000;
      rxBits_ff  <= 4'h0;
      rxSmp_ff   <= '0;
    end else if (mode == serial_port_pkg::MODE_SHIFT ||
                 !ctrl_ff[serial_port_pkg::CB_RXEN]) begin
      rxSt_ff <= serial_port_pkg::RX_IDLE;
    end else if (rxSt_ff == serial_port_pkg::RX_IDLE) begin
      if (rxPrev_ff && !rxLvl_ff) begin
        rxSt_ff  <= serial_port_pkg::RX_START;
        rxSmp_ff <= '0;
      end
    end else if (sampleTick) begin
      rxSmp_ff <= rxSmp_ff + SW'(1);
      if (rxSmp_ff == SMP_MID) begin
        case (rxSt_ff)
          serial_port_pkg::RX_START: begin
            // a start bit that is high again at its centre was noise
            rxSt_ff   <= rxLvl_ff ? serial_port_pkg::RX_IDLE :
                         serial_port_pkg::RX_DATA;
            rxBits_ff <= (mode == serial_port_pkg::MODE_UART8) ?
                         LAST8 : LAST9;
          end
          serial_port_pkg::RX_DATA: begin
            rxShift_ff <= {rxLvl_ff, rxShift_ff[8:1]};
            if (rxBits_ff == 4'h0) begin
              rxSt_ff <= serial_port_pkg::RX_STOP;
            end else begin
              rxBits_ff <= rxBits_ff - 4'h1;
            end
          end
          serial_port_pkg::RX_STOP: rxSt_ff <= serial_port_pkg::RX_IDLE;
          default: rxSt_ff <= serial_port_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // receive buffer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rxBuf_ff <= 8'h00;
    end else if (m0End && m0St_ff == serial_port_pkg::M0_RX) begin
      rxBuf_ff <= {rxLvl_ff, m0Shift_ff[7:1]};
    end else if (rxAccept) begin
      // eight data bits sit high in mode 1, low in modes 2 and 3
      rxBuf_ff <= (mode == serial_port_pkg::MODE_UART8) ?
                  rxShift_ff[8:1] : rxShift_ff[7:0];
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wrCtrl) begin
      nxt_ctrl = sfrReq.wdata;
    end
    // hardware only ever sets the flags, and a set beats a clear
    if (rxAccept) begin
      nxt_ctrl[serial_port_pkg::CB_RXNINTH] = rxNinth;
      nxt_ctrl[serial_port_pkg::CB_RXDONE]  = 1'b1;
    end
    if (m0End && m0St_ff == serial_port_pkg::M0_RX) begin
      nxt_ctrl[serial_port_pkg::CB_RXDONE] = 1'b1;
    end
    if (txSetA || (m0End && m0St_ff == serial_port_pkg::M0_TX)) begin
      nxt_ctrl[serial_port_pkg::CB_TXDONE] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff <= serial_port_pkg::CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ------------------------------------------------------------
  // register read
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdData_ff <= 8'h00;
    end else if (sfrReq.rd) begin
      case (sfrReq.addr)
        serial_port_pkg::ADDR_CTRL: rdData_ff <= ctrl_ff;
        serial_port_pkg::ADDR_DATA: rdData_ff <= rxBuf_ff;
        default: rdData_ff <= 8'h00;
      endcase
    end
  end

  assign sfrRdData = rdData_ff;

  // ------------------------------------------------------------
  // pins
  // ------------------------------------------------------------
  // in mode 0 txd carries the shift clock: low for the first half of
  // each bit, high for the second half
  assign txd = (m0St_ff == serial_port_pkg::M0_IDLE) ? txLine_ff :
               (m0Cnt_ff >= M0_HIGH);
  assign rxdOut  = m0Shift_ff[0];
  assign rxdOe_n = (m0St_ff != serial_port_pkg::M0_TX);

endmodule : four_mode_serial_port

// *** tb/four_mode_serial_port_props.sv ***
// assertion checker for the four-mode serial port
`timescale 1ns/100ps
module four_mode_serial_port_props #(
  parameter int SAMPLES = 16
) (
  // clocks and reset
  input wire logic                      clk_sys,
  input wire logic                      nrst,
  input wire logic                      linkClk,
  // register port
  input wire serial_port_pkg::sfr_req_t sfrReq,
  input wire logic [7:0]                sfrRdData,
  // rate inputs
  input wire logic [1:0]                timerOvf,
  input wire logic                      rateDouble,
  input wire logic                      useTimer2,
  // pins
  input wire logic                      rxdIn,
  input wire logic                      rxdOut,
  input wire logic                      rxdOe_n,
  input wire logic                      txd
);
  logic [7:3] ctrlHi_ff;
  logic [6:0] oeLow_ff;
  logic       wrCtrl;
  logic       wrData;
  logic       rdCtrl;
  logic       mapped;

  assign wrCtrl = sfrReq.wr && sfrReq.addr == serial_port_pkg::ADDR_CTRL;
  assign wrData = sfrReq.wr && sfrReq.addr == serial_port_pkg::ADDR_DATA;
  assign rdCtrl = sfrReq.rd && sfrReq.addr == serial_port_pkg::ADDR_CTRL;
  assign mapped = sfrReq.addr == serial_port_pkg::ADDR_CTRL ||
                  sfrReq.addr == serial_port_pkg::ADDR_DATA;

  // only software changes the upper control bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) ctrlHi_ff <= 5'h00;
    else if (wrCtrl) ctrlHi_ff <= sfrReq.wdata[7:3];
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) oeLow_ff <= 7'h00;
    else oeLow_ff <= rxdOe_n ? 7'h00 : oeLow_ff + 7'h01;
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  rd_unmapped_a: assert property (sfrReq.rd && !mapped |=>
    sfrRdData == 8'h00) else $error("unmapped read not zero");
  ctrl_readback_a: assert property (rdCtrl |=>
    sfrRdData[7:3] == $past(ctrlHi_ff)) else $error("control readback");
  rd_hold_a: assert property (!sfrReq.rd |=>
    $stable(sfrRdData)) else $error("read data moved");
  tx_start_a: assert property (wrData |=> !txd &&
    (ctrlHi_ff[7:6] != 2'h0 || !rxdOe_n)) else $error("no tx start");
  shift_clk_a: assert property ($fell(txd) &&
    ctrlHi_ff[7:6] == 2'h0 |-> !txd [*6] ##1 txd)
    else $error("shift clock shape");
  shift_data_a: assert property (!rxdOe_n && $changed(rxdOut)
    |-> $fell(txd)) else $error("shift data off clock");
  shift_len_a: assert property ($rose(rxdOe_n) |->
    oeLow_ff == 7'h60) else $error("shift length");
  drive_mode_a: assert property (!rxdOe_n |->
    ctrlHi_ff[7:6] == 2'h0) else $error("data pin driven off mode 0");
endmodule : four_mode_serial_port_props

bind four_mode_serial_port four_mode_serial_port_props #(
  .SAMPLES(SAMPLES)
) props_i (
  .clk_sys(clk_sys), .nrst(nrst), .linkClk(linkClk), .sfrReq(sfrReq),
  .sfrRdData(sfrRdData), .timerOvf(timerOvf), .rateDouble(rateDouble),
  .useTimer2(useTimer2), .rxdIn(rxdIn), .rxdOut(rxdOut),
  .rxdOe_n(rxdOe_n), .txd(txd)
);

// *** tb/serial_partner.sv ***
// remote serial device model on the port's pins
`timescale 1ns/100ps
module serial_partner (
  // port pins
  input wire logic txd,
  input wire logic rxdOut,
  input wire logic rxdOe_n,
  // resolved data line
  output logic     rxdIn
);
  logic lineDrv = 1'b1;

  // the port owns the line while it enables its driver
  assign rxdIn = rxdOe_n ? lineDrv : rxdOut;

  // bit 0 first: start, data lsb first, optional ninth, stop
  task automatic send(input logic [10:0] b, input int n, input int bitNs);
    for (int i = 0; i < n; i++) begin
      lineDrv = b[i];
      #(bitNs);
    end
    lineDrv = 1'b1;
  endtask : send

  // first bit may be short, so resync on the end of start (bit0 = 1)
  task automatic grab(input int n, input int bitNs, output logic [10:0] got);
    int w;
    got = 11'h000;
    w = 0;
    while (txd && w < 400000) begin #1; w++; end
    while (!txd && w < 400000) begin #1; w++; end
    #(bitNs / 2);
    for (int i = 0; i < n - 1; i++) begin
      got[i] = txd;
      #(bitNs);
    end
  endtask : grab

  // shift register source: next bit on each falling shift clock, held
  // past the port's late sample point of the last bit
  task automatic feed0(input logic [7:0] b);
    int w;
    w = 0;
    for (int i = 0; i < 8; i++) begin
      while (txd && w < 5000) begin #1; w++; end
      lineDrv = b[i];
      while (!txd && w < 5000) begin #1; w++; end
    end
    #300;
    lineDrv = 1'b1;
  endtask : feed0

  // shift register: takes data on each rising shift clock
  task automatic grab0(output logic [7:0] got);
    int w;
    w = 0;
    for (int i = 0; i < 8; i++) begin
      while (txd && w < 5000) begin #1; w++; end
      while (!txd && w < 5000) begin #1; w++; end
      got[i] = rxdOut;
    end
  endtask : grab0
endmodule : serial_partner

// *** tb/test_four_mode_serial_port.sv ***
// self-checking bench for the four-mode serial port
`timescale 1ns/100ps
module test_four_mode_serial_port;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [7:0] CTRL = serial_port_pkg::ADDR_CTRL;
  localparam logic [7:0] DAT  = serial_port_pkg::ADDR_DATA;
  logic                      clk_sys    = 1'b0;
  logic                      nrst       = 1'b0;
  logic                      linkClk    = 1'b0;
  logic                      ovfPh      = 1'b0;
  serial_port_pkg::sfr_req_t sfrReq     = '0;
  logic [7:0]                sfrRdData;
  logic [1:0]                timerOvf   = 2'h0;
  logic                      rateDouble = 1'b0;
  logic                      useTimer2  = 1'b0;
  logic                      rxdIn;
  logic                      rxdOut;
  logic                      rxdOe_n;
  logic                      txd;
  int                        num_errors = 0;
  int                        n_compared = 0;

  always #12.5 clk_sys = ~clk_sys;
  always #80 linkClk = ~linkClk;

  // one overflow every second link cycle, only on the selected timer
  always @(negedge linkClk) begin
    ovfPh <= ~ovfPh;
    timerOvf <= ovfPh ? {useTimer2, ~useTimer2} : 2'h0;
  end

  four_mode_serial_port uut (.clk_sys(clk_sys), .nrst(nrst),
    .sfrReq(sfrReq), .sfrRdData(sfrRdData), .linkClk(linkClk),
    .timerOvf(timerOvf), .rateDouble(rateDouble), .useTimer2(useTimer2),
    .rxdIn(rxdIn), .rxdOut(rxdOut), .rxdOe_n(rxdOe_n), .txd(txd));
  serial_partner p (.txd(txd), .rxdOut(rxdOut), .rxdOe_n(rxdOe_n),
    .rxdIn(rxdIn));

  // ----------------------------------------
  // bus and report tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [10:0] e,
                       input logic [10:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfrReq.addr = a;
    sfrReq.wdata = d;
    sfrReq.wr = 1'b1;
    @(negedge clk_sys);
    sfrReq.wr = 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    sfrReq.addr = a;
    sfrReq.rd = 1'b1;
    @(negedge clk_sys);
    sfrReq.rd = 1'b0;
    @(negedge clk_sys);
    d = sfrRdData;
  endtask : rd_reg

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] v [2] = '{8'hF8, 8'hA7};
    rd_reg(CTRL, d);
    check("ctrl reset", 11'h000, 11'(d));
    foreach (v[i]) begin
      wr_reg(CTRL, v[i]);
      rd_reg(CTRL, d);
      check("ctrl rw", 11'(v[i]), 11'(d));
    end
    rd_reg(8'h50, d);
    check("unmapped", 11'h000, 11'(d));
  endtask : t_regs

  task automatic t_m0_tx;
    logic [7:0] g;
    logic [7:0] d;
    wr_reg(CTRL, 8'h00);
    fork
      p.grab0(g);
      wr_reg(DAT, 8'h6B);
    join
    check("shift out", 11'h06B, 11'(g));
    repeat (10) @(negedge clk_sys);
    rd_reg(CTRL, d);
    check("shift flag", 11'h002, 11'(d));
  endtask : t_m0_tx

  task automatic t_m0_rx;
    logic [7:0] r;
    logic [7:0] d;
    fork
      p.feed0(8'h9C);
      wr_reg(CTRL, 8'h10);
    join
    repeat (10) @(negedge clk_sys);
    rd_reg(CTRL, r);
    rd_reg(DAT, d);
    check("shift rx flag", 11'h011, 11'(r));
    check("shift in", 11'h09C, 11'(d));
  endtask : t_m0_rx

  task automatic t_tx(input logic [7:0] c, input logic [7:0] d,
                      input logic t2, input logic dbl, input int bitNs,
                      input int n);
    logic [10:0] g;
    logic [7:0]  r;
    useTimer2 = t2;
    rateDouble = dbl;
    wr_reg(CTRL, c);
    fork
      p.grab(n, bitNs, g);
      wr_reg(DAT, d);
    join
    check("frame", n == 11 ? {2'h1, c[3], d} : {3'h1, d}, g);
    rd_reg(CTRL, r);
    check("tx flag", 11'(c | 8'h02), 11'(r));
  endtask : t_tx

  task automatic t_rx(input logic [7:0] c, input logic t2, input int bitNs,
                      input logic [9:0] f, input int n, input logic done,
                      input logic [8:0] e);
    logic [7:0] r;
    logic [7:0] d;
    rateDouble = 1'b0;
    useTimer2 = t2;
    wr_reg(CTRL, c);
    p.send({f, 1'b0}, n, bitNs);
    repeat (20) @(negedge clk_sys);
    rd_reg(CTRL, r);
    rd_reg(DAT, d);
    check("rx flag", 11'(done), 11'(r[0]));
    if (done) check("rx byte", 11'(e), {2'h0, r[2], d});
  endtask : t_rx

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 100000; i++) @(posedge clk_sys);
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (20) @(negedge clk_sys);
    nrst = 1'b1;
    t_regs();
    t_m0_tx();
    t_m0_rx();
    t_tx(8'h48, 8'hA5, 1'b1, 1'b0, 5120, 10);
    t_tx(8'h40, 8'h81, 1'b0, 1'b0, 10240, 10);
    t_tx(8'h80, 8'h3B, 1'b0, 1'b0, 1600, 11);
    t_tx(8'h88, 8'hC7, 1'b0, 1'b1, 800, 11);
    t_tx(8'hC8, 8'h5F, 1'b0, 1'b1, 5120, 11);
    t_rx(8'h50, 1'b1, 5120, 10'h396, 10, 1'b1, 9'h196);
    t_rx(8'h51, 1'b1, 5120, 10'h311, 10, 1'b1, 9'h096);
    t_rx(8'h70, 1'b1, 5120, 10'h222, 10, 1'b0, 9'h000);
    t_rx(8'hF0, 1'b0, 10240, 10'h233, 11, 1'b0, 9'h000);
    t_rx(8'hF0, 1'b0, 10240, 10'h344, 11, 1'b1, 9'h144);
    t_rx(8'h90, 1'b0, 1600, 10'h055, 11, 1'b1, 9'h055);
    t_rx(8'h40, 1'b1, 5120, 10'h366, 10, 1'b0, 9'h000);
    wrap_up();
  end
endmodule : test_four_mode_serial_port
